// file: verilog/sar_adc_seq.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module sar_adc_seq (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep_in,
  input  wire logic        ccp_trigger,
  output logic             timer_clear,
  input  wire logic        rc_clk_in,
  input  wire logic        cmp_in,
  output logic      [2:0]  chan_sel,
  output logic             pos_ref_ext,
  output logic             neg_ref_ext,
  output logic             analog_power_on,
  output logic             sample_en,
  output logic      [9:0]  dac_code,
  output logic             done_flag,
  output logic             busy,
  output logic             wake_req
);
  import sar_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_RC_WAIT, ST_CONV, ST_ABORT} sar_state_t;

  sar_tick_if tif ();

  sar_state_t   state_ff;
  logic [7:0]   ctrl_ff;
  logic [2:0]   div_sel_ff;
  logic [7:0]   res_hi_ff;
  logic [7:0]   res_lo_ff;
  logic         done_ff;
  logic         ien_ff;
  logic         pwr_down_ff;
  logic         timer_clr_ff;
  logic [31:0]  prdata_ff;
  logic         pslverr_ff;
  logic         cmp_q_ff;
  logic [3:0]   per_cnt_ff;
  logic [2:0]   wait_cnt_ff;
  logic [1:0]   abort_cnt_ff;
  logic [9:0]   sar_ff;
  logic [9:0]   nxt_sar;
  logic [9:0]   trial;
  logic         wr_en;
  logic         wr_ctrl;
  logic         on_q;
  logic         rc_sel;
  logic         busy_st;
  logic         start_evt;
  logic         abort_evt;
  logic         sleep_abort;
  logic         complete;
  logic         bus_hit;

  sar_tick_gen u_tick (
    .pclk      (pclk),
    .presetn   (presetn),
    .rc_clk_in (rc_clk_in),
    .tif       (tif.gen)
  );

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // read data is captured in the setup cycle so it comes from a flop;
  // the cost is a fixed single-wait-free access with registered data
  assign wr_en   = psel && penable && pwrite;
  assign wr_ctrl = wr_en && (paddr == OFS_CTRL);
  assign pready  = psel && penable;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff && psel && penable;
  assign bus_hit = (paddr == OFS_CTRL) || (paddr == OFS_CLK) || (paddr == OFS_RES_H) ||
                   (paddr == OFS_RES_L) || (paddr == OFS_FLAG) || (paddr == OFS_IEN);

  // read mux, sampled in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= RD_ZERO;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_ff <= !bus_hit;
      case (paddr)
        OFS_CTRL:  prdata_ff <= {24'h000000, ctrl_ff};
        OFS_CLK:   prdata_ff <= {25'h0000000, div_sel_ff, 4'h0};
        OFS_RES_H: prdata_ff <= {24'h000000, res_hi_ff};
        OFS_RES_L: prdata_ff <= {24'h000000, res_lo_ff};
        OFS_FLAG:  prdata_ff <= {31'h00000000, done_ff};
        OFS_IEN:   prdata_ff <= {31'h00000000, ien_ff};
        default:   prdata_ff <= RD_ZERO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  assign on_q    = ctrl_ff[B_ON];
  assign rc_sel  = (div_sel_ff[1:0] == RC_CODE);
  assign busy_st = (state_ff == ST_RC_WAIT) || (state_ff == ST_CONV);

  // a start needs the converter already on, so a write that turns it on
  // and sets start together only turns it on
  assign start_evt = (state_ff == ST_IDLE) && on_q && !pwr_down_ff &&
                     ((wr_ctrl && pwdata[B_GO] && pwdata[B_ON]) || ccp_trigger);
  assign sleep_abort = busy_st && sleep_in && !rc_sel;
  assign abort_evt   = busy_st && !complete &&
                       ((wr_ctrl && (!pwdata[B_GO] || !pwdata[B_ON])) || sleep_abort);
  assign complete    = (state_ff == ST_CONV) && tif.tick && (per_cnt_ff == LAST_PER);

  // control word; hardware owns the start bit while converting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= REG_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= pwdata[7:0];
        ctrl_ff[B_GO] <= (busy_st && !abort_evt && !complete) || start_evt;
      end else if (start_evt) begin
        ctrl_ff[B_GO] <= 1'b1;
      end else if (complete || abort_evt) begin
        ctrl_ff[B_GO] <= 1'b0;
      end
    end
  end

  // clock select register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_sel_ff <= 3'h0;
    end else if (wr_en && paddr == OFS_CLK) begin
      div_sel_ff <= pwdata[B_DIV_HI:B_DIV_LO];
    end
  end

  // done flag: completion wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
    end else if (complete) begin
      done_ff <= 1'b1;
    end else if (wr_en && paddr == OFS_FLAG) begin
      done_ff <= pwdata[B_DONE];
    end
  end

  // interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_ff <= 1'b0;
    end else if (wr_en && paddr == OFS_IEN) begin
      ien_ff <= pwdata[B_IEN];
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign tif.clk_sel = div_sel_ff;
  assign tif.run     = (state_ff == ST_CONV) || (state_ff == ST_ABORT);

  // state machine: idle acquires, conv runs eleven periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_evt) begin
            state_ff <= rc_sel ? ST_RC_WAIT : ST_CONV;
          end
        end
        ST_RC_WAIT: begin
          if (abort_evt) begin
            state_ff <= ST_ABORT;
          end else if (wait_cnt_ff == INSTR_CYC - 3'h1) begin
            state_ff <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (complete) begin
            state_ff <= ST_IDLE;
          end else if (abort_evt) begin
            state_ff <= ST_ABORT;
          end
        end
        ST_ABORT: begin
          if (tif.tick && abort_cnt_ff == ABORT_PER - 2'h1) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // extra instruction delay counter for the rc clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt_ff <= 3'h0;
    end else if (state_ff == ST_RC_WAIT) begin
      wait_cnt_ff <= wait_cnt_ff + 3'h1;
    end else begin
      wait_cnt_ff <= 3'h0;
    end
  end

  // post-abort settle counter in bit periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_cnt_ff <= 2'h0;
    end else if (state_ff != ST_ABORT) begin
      abort_cnt_ff <= 2'h0;
    end else if (tif.tick) begin
      abort_cnt_ff <= abort_cnt_ff + 2'h1;
    end
  end

  // the comparator is strobed on pclk with the trial code, so one register
  // stage is enough; a two-stage synchroniser would miss the /2 bit period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_q_ff <= 1'b0;
    end else begin
      cmp_q_ff <= cmp_in;
    end
  end

  // period 0 is the hold period, periods 1..10 resolve bits 9..0
  assign trial = SAR_MSB >> (per_cnt_ff - 4'h1);
  always_comb begin
    nxt_sar = sar_ff;
    if (per_cnt_ff != 4'h0) begin
      nxt_sar = (sar_ff & ~(cmp_q_ff ? 10'h000 : trial)) | (trial >> 1);
    end
  end

  // period counter and approximation register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_ff <= 4'h0;
      sar_ff     <= SAR_MSB;
    end else if (state_ff != ST_CONV) begin
      per_cnt_ff <= 4'h0;
      sar_ff     <= SAR_MSB;
    end else if (tif.tick) begin
      per_cnt_ff <= per_cnt_ff + 4'h1;
      sar_ff     <= nxt_sar;
    end
  end

  // result pair takes the code only at completion, never a partial code; bus writes also load it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_hi_ff <= REG_RST;
      res_lo_ff <= REG_RST;
    end else if (complete) begin
      if (ctrl_ff[B_JUST]) begin
        res_hi_ff <= {6'h00, nxt_sar[9:8]};
        res_lo_ff <= nxt_sar[7:0];
      end else begin
        res_hi_ff <= nxt_sar[9:2];
        res_lo_ff <= {nxt_sar[1:0], 6'h00};
      end
    end else if (wr_en && paddr == OFS_RES_H) begin
      res_hi_ff <= pwdata[7:0];
    end else if (wr_en && paddr == OFS_RES_L) begin
      res_lo_ff <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // sleep and trigger side effects
  // ---------------------------------------------------------------
  // power-down leaves the on bit alone; waking from sleep restores power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_down_ff <= 1'b0;
    end else if (sleep_abort) begin
      pwr_down_ff <= 1'b1;
    end else if (complete && sleep_in && rc_sel && !ien_ff) begin
      pwr_down_ff <= 1'b1;
    end else if (!sleep_in) begin
      pwr_down_ff <= 1'b0;
    end
  end

  // timer clear pulse accompanies every accepted trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_clr_ff <= 1'b0;
    end else begin
      timer_clr_ff <= ccp_trigger && on_q;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign chan_sel        = ctrl_ff[B_CHS_HI:B_CHS_LO];
  assign pos_ref_ext     = ctrl_ff[B_POS_REF];
  assign neg_ref_ext     = ctrl_ff[B_NEG_REF];
  assign analog_power_on = on_q && !pwr_down_ff;
  assign sample_en       = analog_power_on && (state_ff == ST_IDLE);
  assign dac_code        = sar_ff;
  assign done_flag       = done_ff;
  assign busy            = ctrl_ff[B_GO];
  assign wake_req        = done_ff && ien_ff && sleep_in;
  assign timer_clear     = timer_clr_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  done_set_a: assert property (complete |=> done_flag && !busy)
    else $error("done flag or start bit wrong after completion");
  flag_sticky_a: assert property (done_flag && !(wr_en && paddr == OFS_FLAG) |=> done_flag)
    else $error("done flag cleared without software");
  // with the /2 divider eleven periods are 22 pclk cycles from entering conv
  conv_len_a: assert property (disable iff (!presetn || abort_evt)
      $rose(state_ff == ST_CONV) && div_sel_ff == 3'h0 |-> ##21 complete)
    else $error("conversion length not eleven periods");
  abort_keep_a: assert property (abort_evt |=> $stable(res_hi_ff) && $stable(res_lo_ff))
    else $error("result changed on abort");
  abort_wait_a: assert property (abort_evt |=> state_ff == ST_ABORT && !sample_en)
    else $error("no settle wait after abort");
  rc_delay_a: assert property (start_evt && rc_sel |=> (state_ff == ST_RC_WAIT)[*4])
    else $error("rc start not delayed one instruction");
  sleep_down_a: assert property (sleep_abort |=> !analog_power_on && on_q)
    else $error("sleep did not power converter down");
  trig_start_a: assert property (ccp_trigger && start_evt |=> busy && timer_clear)
    else $error("trigger did not start and clear timer");
  wake_req_a: assert property (complete && ien_ff && sleep_in |=> wake_req)
    else $error("no wake request after sleep conversion");
  right_just_a: assert property (complete && ctrl_ff[B_JUST] |=> res_hi_ff[7:2] == 6'h00)
    else $error("right justified high bits not zero");
endmodule : sar_adc_seq

// file: shared/sar_pkg.sv
package sar_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;  // converter_control_zero
  localparam logic [7:0] OFS_CLK   = 8'h04;  // converter_clock_config
  localparam logic [7:0] OFS_RES_H = 8'h08;  // result_high_reg
  localparam logic [7:0] OFS_RES_L = 8'h0c;  // result_low_reg
  localparam logic [7:0] OFS_FLAG  = 8'h10;  // peripheral_flag_reg_a
  localparam logic [7:0] OFS_IEN   = 8'h14;  // peripheral_enable_reg_a
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int B_ON      = 0;
  localparam int B_GO      = 1;
  localparam int B_CHS_LO  = 2;
  localparam int B_CHS_HI  = 4;
  localparam int B_POS_REF = 5;
  localparam int B_NEG_REF = 6;
  localparam int B_JUST    = 7;
  localparam int B_DIV_LO  = 4;
  localparam int B_DIV_HI  = 6;
  localparam int B_DONE    = 0;
  localparam int B_IEN     = 0;
  // ---------------------------------------------------------------
  // sizes, reset values, timing
  // ---------------------------------------------------------------
  localparam int          CODE_W     = 10;
  localparam logic [3:0]  LAST_PER   = 4'ha;    // eleventh period index
  localparam logic [1:0]  ABORT_PER  = 2'h2;    // bit periods after abort
  localparam logic [2:0]  INSTR_CYC  = 3'h4;    // pclk cycles per instruction
  localparam logic [9:0]  SAR_MSB    = 10'h200;
  localparam logic [7:0]  REG_RST    = 8'h00;
  localparam logic [1:0]  RC_CODE    = 2'h3;    // low two select bits = rc
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;
endpackage : sar_pkg

// file: shared/sar_tick_if.sv
`timescale 1ns/10ps
// bit period request and strobe between the sequencer and the divider
interface sar_tick_if;
  logic [2:0] clk_sel;
  logic       run;
  logic       tick;
  modport gen  (input clk_sel, input run, output tick);
  modport user (output clk_sel, output run, input tick);
endinterface : sar_tick_if

// file: verilog/sar_tick_gen.sv
`timescale 1ns/10ps
// bit period strobe: divided pclk or edges of the external rc clock
module sar_tick_gen (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic rc_clk_in,
  sar_tick_if.gen   tif
);
  import sar_pkg::*;

  logic [5:0] div_cnt_ff;
  logic [5:0] div_last;
  logic [2:0] rc_sync_ff;
  logic       rc_sel;

  // ---------------------------------------------------------------
  // divisor decode
  // ---------------------------------------------------------------
  // exponent = 2*sel[1:0] + sel[2] + 1 gives /2 /4 /8 /16 /32 /64
  assign rc_sel   = (tif.clk_sel[1:0] == RC_CODE);
  assign div_last = 6'((7'h02 << (2 * tif.clk_sel[1:0] + tif.clk_sel[2])) - 7'h01);

  // rc pin is asynchronous; the third stage only feeds the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_sync_ff <= 3'h0;
    end else begin
      rc_sync_ff <= {rc_sync_ff[1:0], rc_clk_in};
    end
  end

  // divider counter restarts whenever the sequencer is not timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 6'h00;
    end else if (!tif.run || div_cnt_ff == div_last) begin
      div_cnt_ff <= 6'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 6'h01;
    end
  end

  // one strobe per bit period
  assign tif.tick = tif.run && (rc_sel ? (rc_sync_ff[1] && !rc_sync_ff[2])
                                       : (div_cnt_ff == div_last));
endmodule : sar_tick_gen

// file: verif/sar_analog_model.sv
`timescale 1ns/10ps
// analog side stand-in: fixed level per channel and an ideal comparator
module sar_analog_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] chan_sel,
  input  wire logic       analog_power_on,
  input  wire logic [9:0] dac_code,
  output logic            cmp_in
);
  logic [9:0] level;
  logic       toggle_ff;
  // each channel sits at its own level, so a wrong mux shows up in the code
  assign level = {chan_sel, 7'h2b};
  // a powered-down comparator gives no decision; an alternating level exposes any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) toggle_ff <= 1'b0;
    else toggle_ff <= ~toggle_ff;
  end
  // one means keep the trial bit
  assign cmp_in = analog_power_on ? (level >= dac_code) : toggle_ff;
endmodule : sar_analog_model

// file: verif/sar_adc_sequencer_tb_top.sv
`timescale 1ns/10ps
module sar_adc_sequencer_tb_top;
  import sar_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        sleep_in, ccp_trigger, timer_clear, rc_clk_in, cmp_in, ev;
  logic [2:0]  chan_sel;
  logic        pos_ref_ext, neg_ref_ext, analog_power_on, sample_en, done_flag, busy, wake_req;
  logic [9:0]  dac_code, e;
  logic [7:0]  hv, lv;
  logic [2:0]  sel [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  int          dv [7] = '{2, 4, 8, 16, 32, 64, 6}; // rc runs at six pclk periods
  int          err_count, checks, cyc, len;

  sar_adc_seq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_in(sleep_in), .ccp_trigger(ccp_trigger),
    .timer_clear(timer_clear), .rc_clk_in(rc_clk_in), .cmp_in(cmp_in), .chan_sel(chan_sel),
    .pos_ref_ext(pos_ref_ext), .neg_ref_ext(neg_ref_ext), .analog_power_on(analog_power_on),
    .sample_en(sample_en), .dac_code(dac_code), .done_flag(done_flag), .busy(busy),
    .wake_req(wake_req));
  sar_analog_model am (.pclk(pclk), .presetn(presetn), .chan_sel(chan_sel),
    .analog_power_on(analog_power_on), .dac_code(dac_code), .cmp_in(cmp_in));

  // -------------------------------------------------------------
  // clocks and watchdog
  // -------------------------------------------------------------
  always #5 pclk = ~pclk;
  always #30 rc_clk_in = ~rc_clk_in; // free-running oscillator, unrelated phase
  // a hung handshake must still reach the verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // setup, then access held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_idle();
    len = 0;
    while (busy === 1'b1 && len < 2000) begin
      len++;
      @(posedge pclk);
    end
    // a conversion that never ends is a failure, not a silent pass
    if (len == 2000) begin
      err_count++;
      report_and_stop();
    end
  endtask : wait_idle
  // start by a later write than the one turning on, as software must
  task conv(input logic [7:0] ctrl);
    apb(1, OFS_CTRL, {24'h0, ctrl});
    repeat (20) @(posedge pclk); // acquisition delay after channel change
    apb(1, OFS_CTRL, {24'h0, ctrl | 8'h02});
    @(posedge pclk);
    chk(32'(busy), 32'h1);
    wait_idle();
  endtask : conv
  task report_and_stop();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    pclk = 0; rc_clk_in = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; sleep_in = 0; ccp_trigger = 0; err_count = 0; checks = 0; cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped place
    apb(0, OFS_CTRL, 0); chk(rv, RD_ZERO);
    chk({22'h0, dac_code}, {22'h0, SAR_MSB});
    apb(0, OFS_CLK, 0); chk(rv, RD_ZERO);
    apb(0, OFS_FLAG, 0); chk(rv, RD_ZERO);
    apb(0, 8'h40, 0); chk(32'(ev), 32'h1);
    // start in the same write that turns on is ignored
    apb(1, OFS_CTRL, 32'h03);
    repeat (2) @(posedge pclk);
    chk(32'(busy), 32'h0);
    // every divider code, right justified, a different channel each time
    for (int i = 0; i < 7; i++) begin
      apb(1, OFS_FLAG, 0);
      apb(1, OFS_CLK, {25'h0, sel[i], 4'h0});
      conv({1'b1, 2'b00, 3'(i), 2'b01});
      e = {3'(i), 7'h2b};
      chk(32'(len >= 10 * dv[i] && len <= 12 * dv[i] + 8), 32'h1);
      chk(32'(done_flag), 32'h1);
      apb(0, OFS_RES_H, 0); chk(rv, {30'h0, e[9:8]});
      apb(0, OFS_RES_L, 0); chk(rv, {24'h0, e[7:0]});
      apb(0, OFS_CTRL, 0); chk(rv, {24'h0, 1'b1, 2'b00, 3'(i), 2'b01});
    end
    apb(0, OFS_FLAG, 0); chk(rv, 32'h1);
    apb(1, OFS_FLAG, 0); apb(0, OFS_FLAG, 0); chk(rv, 32'h0);
    // left justified, both external references, top channel
    apb(1, OFS_CLK, 32'h00);
    conv(8'h7d);
    chk({29'h0, chan_sel}, 32'h7);
    chk({30'h0, neg_ref_ext, pos_ref_ext}, 32'h3);
    e = {3'h7, 7'h2b};
    hv = e[9:2];
    lv = {e[1:0], 6'h00};
    apb(0, OFS_RES_H, 0); chk(rv, {24'h0, hv});
    apb(0, OFS_RES_L, 0); chk(rv, {24'h0, lv});
    apb(1, OFS_CTRL, 32'h21);
    @(posedge pclk);
    chk({26'h0, neg_ref_ext, pos_ref_ext, 1'b0, chan_sel}, 32'h10);
    // abort mid-conversion keeps the old result
    apb(1, OFS_FLAG, 0);
    apb(1, OFS_CLK, 32'h60);
    apb(1, OFS_CTRL, 32'h87);
    repeat (100) @(posedge pclk);
    apb(1, OFS_CTRL, 32'h85);
    @(posedge pclk);
    chk(32'(busy), 32'h0);
    apb(0, OFS_RES_H, 0); chk(rv, {24'h0, hv});
    apb(0, OFS_RES_L, 0); chk(rv, {24'h0, lv});
    chk(32'(done_flag), 32'h0);
    repeat (140) @(posedge pclk);
    chk(32'(sample_en), 32'h1);
    // hardware trigger
    apb(1, OFS_CLK, 32'h00);
    @(posedge pclk); ccp_trigger <= 1'b1;
    @(posedge pclk); ccp_trigger <= 1'b0;
    @(posedge pclk);
    chk(32'(timer_clear), 32'h1);
    chk(32'(busy), 32'h1);
    wait_idle();
    chk(32'(done_flag), 32'h1);
    // sleep with a divided clock aborts and powers down, then wakes on the flag
    apb(1, OFS_CLK, 32'h60);
    apb(1, OFS_CTRL, 32'h87);
    repeat (50) @(posedge pclk);
    sleep_in <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({30'h0, busy, analog_power_on}, 32'h0);
    apb(0, OFS_CTRL, 0); chk(32'(rv[0]), 32'h1);
    apb(1, OFS_IEN, 32'h1);
    @(posedge pclk);
    chk(32'(wake_req), 32'h1);
    sleep_in <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(wake_req), 32'h0);
    // rc clock in sleep with interrupt off: finishes, then powers down
    apb(1, OFS_IEN, 0);
    apb(1, OFS_FLAG, 0);
    apb(1, OFS_CLK, 32'h30);
    repeat (150) @(posedge pclk);
    apb(1, OFS_CTRL, 32'h87);
    sleep_in <= 1'b1;
    @(posedge pclk);
    wait_idle();
    repeat (3) @(posedge pclk);
    chk({29'h0, done_flag, analog_power_on, wake_req}, 32'h4);
    apb(0, OFS_CTRL, 0); chk(32'(rv[0]), 32'h1);
    sleep_in <= 1'b0;
    // reset in mid-conversion
    repeat (4) @(posedge pclk);
    apb(1, OFS_CLK, 32'h60);
    apb(1, OFS_CTRL, 32'h87);
    repeat (30) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({30'h0, busy, analog_power_on}, 32'h0);
    chk({22'h0, dac_code}, {22'h0, SAR_MSB});
    apb(0, OFS_CTRL, 0); chk(rv, RD_ZERO);
    report_and_stop();
  end
endmodule : sar_adc_sequencer_tb_top
